//--- eelc_pkg.sv
package eelc_pkg;
    // Line counts and source layout
    localparam int NUM_LINES     = 19;  // Total edge-detector lines
    localparam int NUM_PIN_LINES = 16;  // Lines fed from the pin selector
    localparam int NUM_PINS      = 80;  // Selectable general-purpose pins
    localparam int SEL_W         = 7;   // Width of one pin select code
    localparam int LINE_SUPPLY   = 16;  // Supply threshold detector line
    localparam int LINE_ALARM    = 17;  // Calendar alarm line
    localparam int LINE_USBWAKE  = 18;  // Serial-bus wakeup line
    // Values after reset
    localparam logic [NUM_LINES-1:0] LINES_RST = 19'h00000;  // All off, all masked, none pending

    // Per-line configuration, one bit per line in each field
    typedef struct packed {
        logic [NUM_LINES-1:0] rise_en;     // Rising edge triggers
        logic [NUM_LINES-1:0] fall_en;     // Falling edge triggers
        logic [NUM_LINES-1:0] int_unmask;  // Interrupt request allowed
        logic [NUM_LINES-1:0] evt_unmask;  // Event request allowed
    } eelc_cfg_t;

    // Pin selection for the sixteen pin-fed lines
    typedef logic [NUM_PIN_LINES-1:0][SEL_W-1:0] eelc_sel_t;
endpackage

//--- eelc_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Nineteen lines, each interrupt or event capable
// - Per-line rising, falling or both edges
// - Per-line mask, independent of others
// - Readable pending bit per line
// - Capture pulses narrower than clock period
// - Sixteen lines selectable from eighty pins
// - Supply detector, alarm, serial wakeup sources
// - Unmasked trigger wakes from stopped-clock mode
// - Detection and wakeup work without clock
// - Requests wake the processor from sleep
// - Supply detector falling, rising or both
module eelc_ctrl
    import eelc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Line sources
    input  wire logic [NUM_PINS-1:0]  gp_pins,
    input  wire logic                 supply_out,
    input  wire logic                 supply_en,
    input  wire logic                 alarm,
    input  wire logic                 usb_wakeup,
    // Software configuration
    input  wire eelc_cfg_t            cfg,
    input  wire eelc_sel_t            pin_sel,
    input  wire logic [NUM_LINES-1:0] pend_clear,
    // Requests toward the processor interrupt controller
    output logic [NUM_LINES-1:0]      pending,
    output logic [NUM_LINES-1:0]      event_pulse,
    output logic                      cpu_wake,
    // Clockless wakeup from stopped-clock mode
    output logic                      stop_wake
);

    // Pin selector: a code of eighty or more selects nothing
    function automatic logic pick_pin(input logic [NUM_PINS-1:0] pins, input logic [SEL_W-1:0] sel);
        pick_pin = (sel < SEL_W'(NUM_PINS)) ? pins[sel] : 1'b0;
    endfunction

    logic [NUM_LINES-1:0] line_src;     // Raw line levels, not clock-aligned
    logic [NUM_LINES-1:0] rise_tog;     // Flips on every rising edge of the line
    logic [NUM_LINES-1:0] fall_tog;     // Flips on every falling edge of the line
    logic [NUM_LINES-1:0] rise_s1;      // Synchroniser first stage
    logic [NUM_LINES-1:0] rise_s2;      // Synchroniser second stage
    logic [NUM_LINES-1:0] fall_s1;      // Synchroniser first stage
    logic [NUM_LINES-1:0] fall_s2;      // Synchroniser second stage
    logic [NUM_LINES-1:0] rise_ack_reg; // Last toggle value handled
    logic [NUM_LINES-1:0] rise_ack_next;
    logic [NUM_LINES-1:0] fall_ack_reg;
    logic [NUM_LINES-1:0] fall_ack_next;
    logic [NUM_LINES-1:0] trig;         // Qualified edge seen this cycle
    logic [NUM_LINES-1:0] pend_reg;
    logic [NUM_LINES-1:0] pend_next;
    logic [NUM_LINES-1:0] evt_reg;
    logic [NUM_LINES-1:0] evt_next;
    logic                 wake_reg;
    logic                 wake_next;
    logic [NUM_LINES-1:0] async_hit;    // Edge seen but not yet handled

    // Source routing: sixteen selected pins plus three internal sources
    genvar g;
    generate
        for (g = 0; g < NUM_PIN_LINES; g++) begin : g_pin
            assign line_src[g] = pick_pin(gp_pins, pin_sel[g]);
        end
    endgenerate
    // Supply source held low until enabled, so it cannot make edges
    assign line_src[LINE_SUPPLY]  = supply_out & supply_en;
    assign line_src[LINE_ALARM]   = alarm;
    assign line_src[LINE_USBWAKE] = usb_wakeup;

    // Edge capture clocked by the line itself, so a pulse of any width
    // flips a toggle with no help from clk; reset clears it at once
    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_cap
            logic rise_cap_reg;  // Toggle owned by this line's rising edges
            logic fall_cap_reg;  // Toggle owned by this line's falling edges
            always_ff @(posedge line_src[g] or posedge rst) begin
                if (rst) begin
                    rise_cap_reg <= 1'b0;
                end else begin
                    rise_cap_reg <= ~rise_cap_reg;
                end
            end
            always_ff @(negedge line_src[g] or posedge rst) begin
                if (rst) begin
                    fall_cap_reg <= 1'b0;
                end else begin
                    fall_cap_reg <= ~fall_cap_reg;
                end
            end
            // Each process owns a whole variable; the vectors are gathered
            // by plain wiring so no vector has several clocked writers
            assign rise_tog[g] = rise_cap_reg;
            assign fall_tog[g] = fall_cap_reg;
        end
    endgenerate

    // Two-stage synchronisers for the toggles
    always_ff @(posedge clk) begin
        rise_s1 <= rise_tog;
        rise_s2 <= rise_s1;
        fall_s1 <= fall_tog;
        fall_s2 <= fall_s1;
    end

    // Clockless wake: compare live toggles with the handled values;
    // combinational on purpose because no clock runs in stop mode
    assign async_hit = ((rise_tog ^ rise_ack_reg) & cfg.rise_en) | ((fall_tog ^ fall_ack_reg) & cfg.fall_en);
    assign stop_wake = |(async_hit & (cfg.int_unmask | cfg.evt_unmask));

    // Next-state logic for edge handling, pending, events and wake
    always_comb begin
        // Every seen edge is acknowledged, wanted or not, so a stale edge
        // does not fire later when its polarity gets enabled
        rise_ack_next = rise_s2;
        fall_ack_next = fall_s2;
        trig = ((rise_s2 ^ rise_ack_reg) & cfg.rise_en) | ((fall_s2 ^ fall_ack_reg) & cfg.fall_en);
        // Set wins over a simultaneous clear
        pend_next = (pend_reg & ~pend_clear) | (trig & cfg.int_unmask);
        evt_next  = trig & cfg.evt_unmask;
        wake_next = |pend_next | |evt_next;
        if (rst) begin
            rise_ack_next = LINES_RST;
            fall_ack_next = LINES_RST;
            pend_next     = LINES_RST;
            evt_next      = LINES_RST;
            wake_next     = 1'b0;
        end
    end

    // State registers; reset is folded into the next values above
    // Limitation: two same-polarity edges between two clk samples cancel and are missed
    always_ff @(posedge clk) begin
        rise_ack_reg <= rise_ack_next;
        fall_ack_reg <= fall_ack_next;
        pend_reg     <= pend_next;
        evt_reg      <= evt_next;
        wake_reg     <= wake_next;
    end

    assign pending     = pend_reg;
    assign event_pulse = evt_reg;
    assign cpu_wake    = wake_reg;

    // Checks
    property p_pend_set;
        @(posedge clk) disable iff (rst)
        |(trig & cfg.int_unmask) |=> ((pending & $past(trig & cfg.int_unmask)) == $past(trig & cfg.int_unmask));
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("Pending bit not set by unmasked trigger");

    property p_pend_hold;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((pending & $past(pend_reg & ~pend_clear)) == $past(pend_reg & ~pend_clear));
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("Pending bit lost without clear");

    property p_mask;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((pending & ~$past(pend_reg) & ~$past(cfg.int_unmask)) == LINES_RST);
    endproperty
    a_mask: assert property (p_mask) else $error("Masked line set pending");

    property p_evt_only;
        @(posedge clk) disable iff (rst)
        1'b1 |=> (event_pulse == ($past(trig) & $past(cfg.evt_unmask)));
    endproperty
    a_evt_only: assert property (p_evt_only) else $error("Event pulse without its cause");

    property p_reset_clear;
        @(posedge clk) disable iff (rst)
        $past(rst) |-> (pending == LINES_RST && event_pulse == LINES_RST && !cpu_wake);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Requests present after reset");

    property p_cpu_wake;
        @(posedge clk) disable iff (rst)
        (|pend_next || |evt_next) |=> cpu_wake;
    endproperty
    a_cpu_wake: assert property (p_cpu_wake) else $error("Processor wake missing");

    property p_edge_sel;
        @(posedge clk) disable iff (rst)
        ((trig & ~(cfg.rise_en | cfg.fall_en)) == LINES_RST);
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("Trigger on line with no edge selected");

    property p_ack;
        @(posedge clk) disable iff (rst)
        (rise_s2 != rise_ack_reg) |=> (rise_ack_reg == $past(rise_s2));
    endproperty
    a_ack: assert property (p_ack) else $error("Captured edge not handled in one cycle");

    property p_supply_gate;
        @(posedge clk) disable iff (rst)
        !supply_en [*4] |-> !trig[LINE_SUPPLY];
    endproperty
    a_supply_gate: assert property (p_supply_gate) else $error("Disabled supply source triggered");

    property p_pend_cause;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((pending & ~$past(pend_reg) & ~$past(trig & cfg.int_unmask)) == LINES_RST);
    endproperty
    a_pend_cause: assert property (p_pend_cause) else $error("Pending bit set without a trigger");

    property p_clear;
        @(posedge clk) disable iff (rst)
        |(pend_clear & ~(trig & cfg.int_unmask)) |=> ((pending & $past(pend_clear & ~(trig & cfg.int_unmask))) == LINES_RST);
    endproperty
    a_clear: assert property (p_clear) else $error("Pending bit survived its clear");

    property p_wake_level;
        @(posedge clk) disable iff (rst)
        cpu_wake == (|pending || |event_pulse);
    endproperty
    a_wake_level: assert property (p_wake_level) else $error("Processor wake does not follow requests");

endmodule

//--- eelc_src_model.sv
`timescale 1ns/1ps
// Far-side sources: pins and on-chip signals, all idle low
module eelc_src_model
    import eelc_pkg::*;
(
    // Source levels
    output logic [NUM_PINS-1:0] gp_pins,
    output logic                supply_out,
    output logic                alarm,
    output logic                usb_wakeup
);
    initial {gp_pins, supply_out, alarm, usb_wakeup} = '0;
    // Codes 0..79 pins, 80 supply, 81 alarm, 82 serial wakeup
    task automatic drive(input int which, input logic v);
        if (which < NUM_PINS) gp_pins[which] = v;
        else if (which == 80) supply_out = v;
        else if (which == 81) alarm = v;
        else usb_wakeup = v;
    endtask
    // Pulse of 20 ns, narrower than the 100 ns clock, so sampling alone would miss it
    task automatic pulse(input int which);
        drive(which, 1'b1);
        #20 drive(which, 1'b0);
    endtask
endmodule

//--- edge_event_line_controller_test.sv
`timescale 1ns/1ps
module edge_event_line_controller_test;
    import eelc_pkg::*;
    logic                 clk = 1'b0;      // Bench clock
    logic                 rst = 1'b0;      // Raised at start, held for 4 cycles
    eelc_cfg_t            cfg = '0;        // Line configuration
    eelc_sel_t            pin_sel = '0;    // Pin routing
    logic                 supply_en = 1'b0;
    logic [NUM_LINES-1:0] pend_clear = '0;
    logic [NUM_PINS-1:0]  gp_pins;
    logic                 supply_out, alarm, usb_wakeup, cpu_wake, stop_wake;
    logic [NUM_LINES-1:0] pending, event_pulse, ev;
    int                   bad_count = 0;
    int                   n_compared = 0;
    initial forever #50 clk = ~clk;
    eelc_src_model eelc_src_model_inst (.gp_pins(gp_pins), .supply_out(supply_out), .alarm(alarm),
        .usb_wakeup(usb_wakeup));
    eelc_ctrl eelc_ctrl_inst (.clk(clk), .rst(rst), .gp_pins(gp_pins), .supply_out(supply_out),
        .supply_en(supply_en), .alarm(alarm), .usb_wakeup(usb_wakeup), .cfg(cfg), .pin_sel(pin_sel),
        .pend_clear(pend_clear), .pending(pending), .event_pulse(event_pulse), .cpu_wake(cpu_wake),
        .stop_wake(stop_wake));
    // Compare one result; single bits are passed zero-extended
    task automatic check(input string what, input logic [NUM_LINES-1:0] exp, input logic [NUM_LINES-1:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Load the configuration, let it settle one cycle
    task automatic setup(input logic [NUM_LINES-1:0] r, f, im, em);
        @(posedge clk);
        cfg <= '{rise_en: r, fall_en: f, int_unmask: im, evt_unmask: em};
        @(posedge clk);
    endtask
    // Launch a pulse 10 ns after a clock edge, then gather events over 6 cycles, counting cycles with any event
    task automatic fire(input int which, input logic sw, output int n);
        @(posedge clk);
        #10 eelc_src_model_inst.pulse(which);
        #1 check("stop_wake early", {18'h0, sw}, {18'h0, stop_wake});
        ev = '0;
        n = 0;
        repeat (6) begin
            @(posedge clk);
            #1 ev = ev | event_pulse;
            n += (event_pulse != 0);
        end
    endtask
    // Nothing raised out of reset, even when a source moves
    task automatic t_reset();
        int n;
        fire(0, 1'b0, n);
        check("pending", 19'h00000, pending);
        check("events", 19'h00000, ev);
        check("cpu_wake", 19'h00000, {18'h0, cpu_wake});
    endtask
    // Pin 79 routed to line 0, narrow rising pulse
    task automatic t_pin_rise();
        int n;
        @(posedge clk);
        pin_sel[0] <= 7'h4F;
        setup(19'h00001, 19'h00000, 19'h00001, 19'h00001);
        fire(79, 1'b1, n);
        check("pending", 19'h00001, pending);
        check("events", 19'h00001, ev);
        check("event cycles", 19'h00001, 19'(n));
        check("cpu_wake", 19'h00001, {18'h0, cpu_wake});
        check("stop_wake late", 19'h00000, {18'h0, stop_wake});
    endtask
    // Pin 5 on lines 1..3: falling, masked both, rising
    task automatic t_fall_mask();
        int n;
        @(posedge clk);
        pin_sel[1] <= 7'h05;
        pin_sel[2] <= 7'h05;
        pin_sel[3] <= 7'h05;
        setup(19'h0000D, 19'h00006, 19'h0000B, 19'h00000);
        fire(5, 1'b1, n);
        check("pending", 19'h0000B, pending);
        check("events", 19'h00000, ev);
    endtask
    // Write one clears only its own bit
    task automatic t_clear();
        @(posedge clk);
        pend_clear <= 19'h00002;
        @(posedge clk);
        pend_clear <= 19'h00000;
        @(posedge clk);
        #1 check("pending", 19'h00009, pending);
        @(posedge clk);
        pend_clear <= 19'h7FFFF;
        @(posedge clk);
        pend_clear <= 19'h00000;
        repeat (2) @(posedge clk);
        #1 check("pending", 19'h00000, pending);
        check("cpu_wake", 19'h00000, {18'h0, cpu_wake});
    endtask
    // Alarm and serial wakeup as events only
    task automatic t_events();
        int n;
        setup(19'h60000, 19'h00000, 19'h00000, 19'h60000);
        fire(81, 1'b1, n);
        check("events", 19'h20000, ev);
        fire(82, 1'b1, n);
        check("events", 19'h40000, ev);
        check("pending", 19'h00000, pending);
    endtask
    // Supply line dead until enabled, then both directions
    task automatic t_supply();
        int n;
        setup(19'h10000, 19'h10000, 19'h10000, 19'h00000);
        fire(80, 1'b0, n);
        check("pending", 19'h00000, pending);
        @(posedge clk);
        supply_en <= 1'b1;
        repeat (2) @(posedge clk);
        #10 eelc_src_model_inst.drive(80, 1'b1);
        repeat (6) @(posedge clk);
        #1 check("pending", 19'h10000, pending);
        @(posedge clk);
        pend_clear <= 19'h10000;
        @(posedge clk);
        pend_clear <= 19'h00000;
        #1 check("pending", 19'h00000, pending);
        #9 eelc_src_model_inst.drive(80, 1'b0);
        repeat (6) @(posedge clk);
        #1 check("pending", 19'h10000, pending);
    endtask
    // Verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // A real rising edge on reset clears the line-clocked toggles at time 0
    initial begin
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pin_rise();
        t_fall_mask();
        t_clear();
        t_events();
        t_supply();
        stop_test();
    end
    // Run needs about 8 us; cut a hang well beyond that
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
endmodule
